//--- iod_map.vh
`ifndef IOD_MAP_VH
`define IOD_MAP_VH
// apb register offsets
`define IOD_CTRL_OFF 12'h000
`define IOD_INSN_OFF 12'h004
`define IOD_ADDR_OFF 12'h008
`define IOD_RES_OFF 12'h00c
`define IOD_STAT_OFF 12'h010
`define IOD_CLR_OFF 12'h014
`define IOD_EN_OFF 12'h018
// ctrl fields
`define IOD_CTRL_LVL_LO 0
`define IOD_CTRL_LVL_HI 2
`define IOD_CTRL_COMPAT2 3
`define IOD_CTRL_CU0 4
`define IOD_CTRL_CU1 5
`define IOD_CTRL_CU2 6
`define IOD_CTRL_BIGEND 7
`define IOD_CTRL_SYS_LDST 8
`define IOD_CTRL_RST 32'h0000_0004
// result fields
`define IOD_RES_CLASS_LO 0
`define IOD_RES_CLASS_HI 3
`define IOD_RES_RI 4
`define IOD_RES_CPU 5
`define IOD_RES_ADEL 6
`define IOD_RES_STALL 7
`define IOD_RES_IDX 8
`define IOD_RES_FPXFER 9
`define IOD_RES_CTRLREG 10
`define IOD_RES_DWORD 11
`define IOD_RES_MSB_LO 12
`define IOD_RES_MSB_HI 14
// status bits: ri, cpu, adel, stall
`define IOD_NEV 4
// operation classes
`define IOD_C_NONE 4'h0
`define IOD_C_INT 4'h1
`define IOD_C_FUNC 4'h2
`define IOD_C_RIMM 4'h3
`define IOD_C_FPCLS 4'h4
`define IOD_C_FPIDX 4'h5
`define IOD_C_FPLS 4'h6
`define IOD_C_LDST 4'h7
`define IOD_C_PREFETCH_OP 4'h8
`define IOD_C_COP 4'h9
`endif

//--- iod_decoder.v
`timescale 1ns/1ps
`include "iod_map.vh"
module iod_decoder (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq
);

// ------------------------------------------------
// registers
// ------------------------------------------------
reg [31:0] ctrl_q;
reg [31:0] insn_q;
reg [31:0] addr_q;
reg [15:0] res_q;
wire [`IOD_NEV-1:0] stat_q;
reg [`IOD_NEV-1:0] en_q;
reg [4:0] last_ft_q;
reg last_fpload_q;
reg [`IOD_NEV-1:0] ev;

wire wr = psel & penable & pwrite;
wire is_ctrl = (paddr == `IOD_CTRL_OFF);
wire is_insn = (paddr == `IOD_INSN_OFF);
wire is_addr = (paddr == `IOD_ADDR_OFF);
wire is_res = (paddr == `IOD_RES_OFF);
wire is_stat = (paddr == `IOD_STAT_OFF);
wire is_clr = (paddr == `IOD_CLR_OFF);
wire is_en = (paddr == `IOD_EN_OFF);
wire mapped = is_ctrl | is_insn | is_addr | is_res | is_stat | is_clr | is_en;

assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;
assign irq = |(stat_q & en_q);

// ------------------------------------------------
// field extraction
// ------------------------------------------------
wire [2:0] lvl = ctrl_q[`IOD_CTRL_LVL_HI:`IOD_CTRL_LVL_LO];
wire [2:0] elvl = ctrl_q[`IOD_CTRL_COMPAT2] && lvl > 3'd2 ? 3'd2 : lvl;
wire l2 = elvl >= 3'd2;
wire l3 = elvl >= 3'd3;
wire l4 = elvl >= 3'd4;
wire [2:0] orow = insn_q[31:29];
wire [2:0] ocol = insn_q[28:26];
wire [2:0] frow = insn_q[5:3];
wire [2:0] fcol = insn_q[2:0];
wire [4:0] rt = insn_q[20:16];
wire [4:0] rs = insn_q[25:21];
wire [4:0] ft = insn_q[20:16];

// ------------------------------------------------
// decode
// ------------------------------------------------
reg [3:0] cls;
reg ri;
reg cpu;
reg fpins;
reg fpload;
reg idx;
reg ctrlreg;
reg dword;
reg [2:0] asize;
reg [4:0] dst;
always @* begin
    cls = `IOD_C_INT;
    ri = 1'b0;
    cpu = 1'b0;
    fpins = 1'b0;
    fpload = 1'b0;
    idx = 1'b0;
    ctrlreg = 1'b0;
    dword = 1'b0;
    asize = 3'd0;
    dst = ft;
    case (orow)
        3'd0: begin
            if (ocol == 3'd0) begin
                cls = `IOD_C_FUNC;
                case (frow)
                    3'd0: ri = (fcol == 3'd5) | (fcol == 3'd1 & ~l4);
                    3'd1: begin
                        if (fcol == 3'd2 || fcol == 3'd3)
                            ri = ~l4;
                        else if (fcol == 3'd7)
                            ri = ~l2;
                        else
                            ri = (fcol == 3'd6) | (fcol == 3'd3);
                    end
                    3'd2: ri = (fcol == 3'd5) | (fcol[2] & ~l3);
                    3'd3: ri = fcol[2] & ~l3;
                    3'd4: ri = 1'b0;
                    3'd5: ri = (fcol[2:1] == 2'd0) | ~l3 & (fcol[2:1] != 2'd1);
                    3'd6: ri = (fcol == 3'd5) | (fcol == 3'd7) | ~l2;
                    default: ri = (fcol == 3'd1) | (fcol == 3'd5) | ~l3;
                endcase
            end else if (ocol == 3'd1) begin
                cls = `IOD_C_RIMM;
                if (rt[4:3] == 2'd0)
                    ri = rt[2] | (rt[1] & ~l2);
                else if (rt[4:3] == 2'd1)
                    ri = (rt[2:0] == 3'd5) | (rt[2:0] == 3'd7) | ~l2;
                else if (rt[4:3] == 2'd2)
                    ri = rt[2:1] != 2'd0 | rt[1];
                else
                    ri = 1'b1;
            end
        end
        3'd1: cls = `IOD_C_INT;
        3'd2: begin
            if (ocol[2]) begin
                ri = ~l2;
            end else if (ocol == 3'd1) begin
                cls = `IOD_C_FPCLS;
                fpins = 1'b1;
                cpu = ~ctrl_q[`IOD_CTRL_CU1];
                // control register moves are word only
                ctrlreg = (rs == 5'd2) | (rs == 5'd6);
                dword = (rs == 5'd1) | (rs == 5'd5);
                ri = dword & ~l3;
                dst = insn_q[15:11];
                fpload = (rs == 5'd4) | (rs == 5'd5);
            end else if (ocol == 3'd3) begin
                // indexed fp class, level four only
                cls = `IOD_C_FPIDX;
                ri = ~l4;
                fpins = l4;
                cpu = l4 & ~ctrl_q[`IOD_CTRL_CU1];
                idx = l4;
                dword = insn_q[0];
                asize = insn_q[0] ? 3'd7 : 3'd3;
                fpload = l4 & (insn_q[5:3] == 3'd0);
                dst = insn_q[10:6];
            end else begin
                cls = `IOD_C_COP;
                cpu = ocol[1] ? ~ctrl_q[`IOD_CTRL_CU2] : ~ctrl_q[`IOD_CTRL_CU0];
            end
        end
        3'd3: begin
            // wide immediates and unaligned doubleword loads
            ri = ocol[2] | ~l3;
        end
        3'd4: begin
            cls = `IOD_C_LDST;
            ri = (ocol == 3'd7) & ~l3;
        end
        3'd5: begin
            cls = `IOD_C_LDST;
            ri = (ocol == 3'd7) | ((ocol == 3'd4 || ocol == 3'd5) & ~l3);
        end
        default: begin
            cls = `IOD_C_LDST;
            case (ocol)
                3'd0: ri = ~l2;
                3'd1: begin
                    cls = `IOD_C_FPLS;
                    fpins = 1'b1;
                    cpu = ~ctrl_q[`IOD_CTRL_CU1];
                    asize = 3'd3;
                    fpload = ~orow[0];
                end
                3'd2: begin
                    cls = `IOD_C_COP;
                    cpu = ~ctrl_q[`IOD_CTRL_CU2];
                end
                3'd3: begin
                    if (!orow[0] && l4)
                        cls = `IOD_C_PREFETCH_OP;
                    else
                        ri = ~l3 | orow[0];
                end
                3'd4: ri = ~l3;
                3'd5: begin
                    cls = `IOD_C_FPLS;
                    fpins = l2;
                    ri = ~l2;
                    cpu = l2 & ~ctrl_q[`IOD_CTRL_CU1];
                    asize = 3'd7;
                    dword = 1'b1;
                    fpload = l2 & ~orow[0];
                end
                3'd6: begin
                    cls = `IOD_C_COP;
                    ri = ~ctrl_q[`IOD_CTRL_SYS_LDST] | ~l2;
                    cpu = ~ri & ~ctrl_q[`IOD_CTRL_CU0];
                end
                default: begin
                    ri = ~l3;
                    dword = 1'b1;
                end
            endcase
        end
    endcase
end

wire adel = ~ri & ~cpu & ((addr_q[2:0] & asize) != 3'd0);
// msb byte lane: big endian lowest, else highest
wire [2:0] msb_lane = ctrl_q[`IOD_CTRL_BIGEND] ? addr_q[2:0] : addr_q[2:0] | asize;
// stall when next use reads last fp load target
wire uses_ft = fpins & ~fpload & ((insn_q[20:16] == last_ft_q) | (insn_q[15:11] == last_ft_q));
wire stall = l2 & last_fpload_q & uses_ft;

// ------------------------------------------------
// write strobes and retire qualifiers
// ------------------------------------------------
wire wr_ctrl = wr & is_ctrl;
wire wr_insn = wr & is_insn;
wire wr_addr = wr & is_addr;
wire wr_clr = wr & is_clr;
wire wr_en = wr & is_en;
wire fp_xfer = fpins & ~ri & ~cpu;
wire load_retires = fpload & ~ri & ~cpu & ~adel;

// ------------------------------------------------
// event vector
// ------------------------------------------------
always @* begin
    ev = {stall, adel, cpu, ri};
end

// ------------------------------------------------
// software registers
// ------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_q <= `IOD_CTRL_RST;
    end else if (wr_ctrl) begin
        ctrl_q <= pwdata;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        insn_q <= 32'h0000_0000;
    end else if (wr_insn) begin
        insn_q <= pwdata;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        addr_q <= 32'h0000_0000;
    end else if (wr_addr) begin
        addr_q <= pwdata;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        en_q <= {`IOD_NEV{1'b0}};
    end else if (wr_en) begin
        en_q <= pwdata[`IOD_NEV-1:0];
    end
end

// ------------------------------------------------
// decode result
// ------------------------------------------------
// transfer flag only, no fp trap bits
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        res_q <= 16'h0000;
    end else begin
        res_q <= {1'b0, msb_lane, dword, ctrlreg, fp_xfer, idx, stall, adel, cpu, ri, cls};
    end
end

// instruction retires when next is written
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        last_fpload_q <= 1'b0;
        last_ft_q <= 5'd0;
    end else if (wr_insn) begin
        last_fpload_q <= load_retires;
        last_ft_q <= dst;
    end
end

// ------------------------------------------------
// sticky status, one flop per event
// ------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < `IOD_NEV; gi = gi + 1) begin : g_stat
        reg flag_q;
        // set wins over clear
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_q <= 1'b0;
            end else if (ev[gi] && !wr_insn) begin
                flag_q <= 1'b1;
            end else if (wr_clr && pwdata[gi]) begin
                flag_q <= 1'b0;
            end
        end
        assign stat_q[gi] = flag_q;
    end
endgenerate

// ------------------------------------------------
// read data
// ------------------------------------------------

always @* begin
    if (is_ctrl)
        prdata = ctrl_q;
    else if (is_insn)
        prdata = insn_q;
    else if (is_addr)
        prdata = addr_q;
    else if (is_res)
        prdata = {16'h0000, res_q};
    else if (is_stat)
        prdata = {{(32-`IOD_NEV){1'b0}}, stat_q};
    else if (is_en)
        prdata = {{(32-`IOD_NEV){1'b0}}, en_q};
    else
        prdata = 32'h0000_0000;
end

endmodule // iod_decoder

//--- iod_decoder_assertions.sv
`timescale 1ns/1ps
`include "iod_map.vh"
module iod_decoder_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq
);
    // ------------------------------
    // shadow of written registers
    // ------------------------------
    reg [31:0] ctrl_q;
    reg [31:0] insn_q;
    reg [31:0] addr_q;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd_res = acc && !pwrite && paddr == `IOD_RES_OFF;
    wire mapped = paddr <= `IOD_EN_OFF && paddr[1:0] == 2'b00;
    wire [5:0] op = insn_q[31:26];
    wire [2:0] lvl = ctrl_q[2:0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `IOD_CTRL_RST;
            insn_q <= 32'h0000_0000;
            addr_q <= 32'h0000_0000;
        end else if (wr) begin
            if (paddr == `IOD_CTRL_OFF) ctrl_q <= pwdata;
            if (paddr == `IOD_INSN_OFF) insn_q <= pwdata;
            if (paddr == `IOD_ADDR_OFF) addr_q <= pwdata;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------
    // decode results, slave error and irq
    // ------------------------------
    AST_RSV_TRAP: assert property (rd_res && op == 6'h1c |-> prdata[4])
        else $error("reserved slot did not trap");
    AST_FUNC_SEL: assert property (rd_res && op == 6'h00 && insn_q[5:0] == 6'h20
        |-> prdata[3:0] == `IOD_C_FUNC && !prdata[4]) else $error("function decode wrong");
    AST_COP_UNUSE: assert property (rd_res && op == 6'h12 && !ctrl_q[6] |-> prdata[5])
        else $error("coprocessor 2 usable while off");
    AST_FP_UNUSE: assert property (rd_res && op == 6'h11 |-> prdata[5] == !ctrl_q[5])
        else $error("fp unusable flag wrong");
    AST_ALIGN: assert property (rd_res && op == 6'h35 && ctrl_q[5]
        |-> prdata[6] == (addr_q[2:0] != 3'h0)) else $error("address error wrong");
    AST_MSB_LANE: assert property (rd_res && op == 6'h31 && ctrl_q[5] && addr_q == 0
        |-> prdata[14:12] == (ctrl_q[7] ? 3'h0 : 3'h3)) else $error("msb lane wrong");
    AST_LVL2: assert property (rd_res && op == 6'h30 |-> prdata[4] == (lvl < 3'h2))
        else $error("level two gating wrong");
    AST_LVL3: assert property (rd_res && op == 6'h27 && !ctrl_q[3]
        |-> prdata[4] == (lvl < 3'h3)) else $error("level three gating wrong");
    AST_LVL4: assert property (rd_res && insn_q == 32'h0000_000a && !ctrl_q[3]
        |-> prdata[4] == (lvl < 3'h4)) else $error("level four gating wrong");
    AST_COMPAT: assert property (rd_res && op == 6'h37 && ctrl_q[3] |-> prdata[4])
        else $error("removed opcode did not trap");
    AST_UNMAPPED: assert property (acc |-> pslverr == !mapped)
        else $error("slave error wrong");
    AST_IRQ_OFF: assert property (wr && paddr == `IOD_EN_OFF && pwdata[3:0] == 4'h0
        |=> !irq [*2]) else $error("irq with all enables off");
endmodule // iod_decoder_assertions

//--- iod_apb_master.sv
`timescale 1ns/1ps
module iod_apb_master (
    input wire pclk,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // iod_apb_master

//--- iod_decoder_tb.sv
`timescale 1ns/1ps
`include "iod_map.vh"
module iod_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, a;
    int fails = 0;
    int cmp_count = 0;
    iod_decoder iod_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    iod_apb_master iod_apb_master_i (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] exp_adel(input logic [31:0] v, input logic dw);
        return ((dw ? v[2:0] : {1'b0, v[1:0]}) != 3'h0) ? 32'h0000_0040 : 32'h0000_0000;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x);
        @(negedge pclk);
        chk({31'h0, g}, {31'h0, x});
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        iod_apb_master_i.xfer(1'b1, ad, d, r, e);
    endtask
    task automatic rd(input logic [11:0] ad);
        iod_apb_master_i.xfer(1'b0, ad, 32'h0000_0000, r, e);
    endtask
    task automatic dec(input logic [31:0] c, i, ad, m, x);
        wr(`IOD_CTRL_OFF, c);
        wr(`IOD_INSN_OFF, i);
        wr(`IOD_ADDR_OFF, ad);
        rd(`IOD_RES_OFF);
        chk(r & m, x);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report;
    end
    initial begin
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IOD_CTRL_OFF);
        chk(r, `IOD_CTRL_RST);
        rd(`IOD_EN_OFF);
        chk(r, 32'h0000_0000);
        rd(12'h01c);
        chk1(e, 1'b1);
        wr(`IOD_EN_OFF, 32'h0000_000f);
        dec(32'h0000_0024, 32'h7000_0000, 0, 32'h10, 32'h10);
        chk1(irq, 1'b1);
        wr(`IOD_INSN_OFF, 32'h0000_0020);
        wr(`IOD_CLR_OFF, 32'h0000_000f);
        rd(`IOD_STAT_OFF);
        chk(r & 32'h1, 32'h0);
        chk1(irq, 1'b0);
        wr(`IOD_INSN_OFF, 32'h7000_0000);
        wr(`IOD_EN_OFF, 32'h0000_0000);
        rd(`IOD_STAT_OFF);
        chk(r & 32'h1, 32'h1);
        chk1(irq, 1'b0);
        dec(32'h0000_0024, 32'h0000_0005, 0, 32'h10, 32'h10);
        dec(32'h0000_0024, 32'h0000_0020, 0, 32'h1f, 32'h02);
        dec(32'h0000_0021, 32'h0402_0000, 0, 32'h10, 32'h10);
        dec(32'h0000_0022, 32'h0402_0000, 0, 32'h1f, 32'h03);
        dec(32'h0000_0004, 32'h4400_0000, 0, 32'h20, 32'h20);
        dec(32'h0000_0024, 32'h4400_0000, 0, 32'h3f, 32'h04);
        dec(32'h0000_0024, 32'h4800_0000, 0, 32'h20, 32'h20);
        dec(32'h0000_0021, 32'hc000_0000, 0, 32'h10, 32'h10);
        dec(32'h0000_0022, 32'hc000_0000, 0, 32'h10, 32'h00);
        dec(32'h0000_0022, 32'h9c00_0000, 0, 32'h10, 32'h10);
        dec(32'h0000_0023, 32'h9c00_0000, 0, 32'h10, 32'h00);
        dec(32'h0000_0023, 32'h0000_000a, 0, 32'h10, 32'h10);
        dec(32'h0000_0024, 32'h0000_000a, 0, 32'h10, 32'h00);
        dec(32'h0000_0024, 32'h4c00_0000, 0, 32'h10f, 32'h105);
        dec(32'h0000_0023, 32'h4c00_0000, 0, 32'h100, 32'h0);
        dec(32'h0000_002c, 32'hdc00_0000, 0, 32'h10, 32'h10);
        dec(32'h0000_0024, 32'hd400_0000, 8, 32'he40, 32'ha00);
        dec(32'h0000_0024, 32'h4440_0000, 0, 32'h400, 32'h400);
        dec(32'h0000_0024, 32'hc400_0000, 2, 32'h40, 32'h40);
        dec(32'h0000_0024, 32'hc400_0000, 0, 32'h7000, 32'h3000);
        dec(32'h0000_00a4, 32'hc400_0000, 0, 32'h7000, 32'h0);
        dec(32'h0000_0124, 32'hd800_0000, 0, 32'h30, 32'h20);
        dec(32'h0000_0024, 32'hd800_0000, 0, 32'h30, 32'h10);
        dec(32'h0000_0024, 32'hc402_0000, 0, 32'h80, 32'h00);
        dec(32'h0000_0024, 32'he402_0000, 0, 32'h80, 32'h80);
        dec(32'h0000_0021, 32'hc402_0000, 0, 32'h80, 32'h00);
        dec(32'h0000_0021, 32'he402_0000, 0, 32'h80, 32'h00);
        a = 32'h0000_0042;
        repeat (24) begin
            a = lfsr(a);
            dec(32'h0000_0024, a[31] ? 32'hd400_0000 : 32'hc400_0000, a, 32'h40, exp_adel(a, a[31]));
        end
        final_report;
    end
endmodule // iod_decoder_tb
bind iod_decoder iod_decoder_assertions iod_decoder_assertions_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
